// *** tdcfc_clk_div.sv ***
// enable divider producing the fire half-period tick
// assumes clear_i restarts the count so trains start phase aligned
module tdcfc_clk_div #(
    parameter int HALF_CYCLES = tdcfc_pkg::FIRE_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control
    input wire logic clear_i,
    output logic tick_o
);

    localparam logic [tdcfc_pkg::DIV_W-1:0] LAST = tdcfc_pkg::DIV_W'(HALF_CYCLES - 1);
    logic [tdcfc_pkg::DIV_W-1:0] cnt_r;

    // counter restarts on clear, wraps after each half period
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= '0;
        end else if (clear_i || cnt_r == LAST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick_o = !clear_i && (cnt_r == LAST);

endmodule // tdcfc_clk_div

// *** tdcfc_fire_train.sv ***
// fire pulse train sequencer with per-pulse phase and repetition
// assumes tick_i is a one-cycle enable at the fire half period
module tdcfc_fire_train (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [tdcfc_pkg::COUNT_W-1:0] pulse_count_i,
    input wire logic [tdcfc_pkg::REPEAT_W-1:0] repeat_i,
    input wire logic [tdcfc_pkg::PHASE_W-1:0] phase_i,
    // status and waveform
    output logic busy_o,
    output logic wave_o
);

    typedef enum logic [2:0] {
        TDCFC_IDLE = 3'b001,
        TDCFC_HIGH = 3'b010,
        TDCFC_LOW = 3'b100
    } tdcfc_state_t;

    tdcfc_state_t state_r;
    logic [tdcfc_pkg::COUNT_W-1:0] idx_r;
    logic [tdcfc_pkg::REPEAT_W-1:0] rep_r;
    logic wave_r;
    logic [tdcfc_pkg::COUNT_W-1:0] idx_nxt;

    assign idx_nxt = idx_r + 1'b1;

    // train walks pulses in order, then repeats the whole sequence
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= TDCFC_IDLE;
            idx_r <= '0;
            rep_r <= '0;
        end else begin
            unique case (state_r)
                TDCFC_IDLE: begin
                    // a zero pulse count would fire nothing, so start is ignored
                    if (start_i && pulse_count_i != '0) begin
                        state_r <= TDCFC_HIGH;
                        idx_r <= '0;
                        rep_r <= '0;
                    end
                end
                TDCFC_HIGH: begin
                    if (tick_i) begin
                        state_r <= TDCFC_LOW;
                    end
                end
                TDCFC_LOW: begin
                    if (tick_i) begin
                        if (idx_nxt < pulse_count_i) begin
                            idx_r <= idx_nxt; // [RL17]
                            state_r <= TDCFC_HIGH;
                        end else if (rep_r < repeat_i) begin
                            rep_r <= rep_r + 1'b1; // [RL14]
                            idx_r <= '0;
                            state_r <= TDCFC_HIGH;
                        end else begin
                            state_r <= TDCFC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // phase bit of the current pulse inverts it; idle line stays low
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wave_r <= 1'b0;
        end else if (state_r == TDCFC_IDLE && !(start_i && pulse_count_i != '0)) begin
            wave_r <= 1'b0;
        end else if (state_r == TDCFC_IDLE) begin
            wave_r <= !phase_i[0]; // [RL15]
        end else if (tick_i && state_r == TDCFC_HIGH) begin
            wave_r <= phase_i[idx_r]; // [RL15]
        end else if (tick_i && state_r == TDCFC_LOW && idx_nxt < pulse_count_i) begin
            wave_r <= !phase_i[idx_nxt]; // [RL17]
        end else if (tick_i && state_r == TDCFC_LOW && rep_r < repeat_i) begin
            wave_r <= !phase_i[0]; // [RL14]
        end else if (tick_i) begin
            wave_r <= 1'b0;
        end
    end

    assign busy_o = (state_r != TDCFC_IDLE);
    assign wave_o = wave_r;

    // first pulse of a train follows the lowest phase bit
    first_phase_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL17]
        (state_r == TDCFC_IDLE && start_i && pulse_count_i != '0)
        |=> (wave_o == !$past(phase_i[0])))
        else $error("first pulse phase wrong");

endmodule // tdcfc_fire_train

// *** tdcfc_host_model.sv ***
// host model that programs the configuration registers
// assumes read data arrive the cycle after the read strobe
module tdcfc_host_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0000_0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write; data inverted after release so stale data never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == 8'h04) d[31:27] = 5'h02;
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // one-cycle read, data taken in the cycle after
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule // tdcfc_host_model

// *** tdcfc_pkg.sv ***
// constants shared by the stop-window and fire configuration block
// assumes a single 100 MHz clock and a plain address/strobe register port
package tdcfc_pkg;

    // ------------------------------------------------------------------
    // register map (printed offsets, used directly as word addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_DELAY_IDX = 8'h04;
    localparam logic [ADDR_W-1:0] REG_FIRE_IDX = 8'h05;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DELAY_RESET = 32'h1000_0000;
    localparam logic [DATA_W-1:0] FIRE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // delay register fields
    // ------------------------------------------------------------------
    localparam int TAG_LSB = 0;
    localparam int TAG_W = 8;
    localparam int DELAY_LSB = 8;
    localparam int DELAY_W = 19;
    localparam int DELAY_FRAC_W = 5;
    localparam int DELAY_INT_W = 14;
    localparam int KEEP_LSB = 27;
    localparam int KEEP_W = 5;
    localparam int PW_OFF_BIT = 16;
    localparam int EDGE_BIT = 15;
    localparam int POS_COMPARATOR_TRIM_BIT = 14;
    localparam int NEG_COMPARATOR_TRIM_BIT = 13;
    localparam int TRIM_LSB = 8;
    localparam int TRIM_W = 5;
    localparam int COMPARATOR_TRIM_W = 7;
    localparam logic signed [COMPARATOR_TRIM_W-1:0] EXTRA_COMPARATOR_TRIM_MV = 7'sh14;

    // ------------------------------------------------------------------
    // fire register fields
    // ------------------------------------------------------------------
    localparam int BOTH_ON_BIT = 31;
    localparam int UP_OFF_BIT = 30;
    localparam int DOWN_OFF_BIT = 29;
    localparam int START_NOISE_BIT = 28;
    localparam int NOISE_CTRL_BIT = 27;
    localparam int REPEAT_LSB = 24;
    localparam int REPEAT_W = 3;
    localparam int PHASE_LSB = 8;
    localparam int PHASE_W = 16;
    localparam int MAX_PULSES = 15;
    localparam int COUNT_W = 4;

    // ------------------------------------------------------------------
    // fire timing
    // ------------------------------------------------------------------
    localparam int FIRE_HALF_CYCLES = 4;
    localparam int DIV_W = 8;

endpackage

// *** tdcfc_top.sv ***
// stop-window / first-wave setup register and fire generator configuration
// assumes a host on a plain strobe port, first-wave enable from another register
// and a fire start pulse and pulse count supplied by the measurement core

// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
// Overview of operation
// RL1 - without first-wave mode, bits 26..8 hold the third stop-enable delay
// RL2 - delay is unsigned fixed point, 14 integer and 5 fraction bits, ref periods
// RL3 - bits 7..0 of both registers are free tag storage, no effect
// RL4 - host writes 2 into bits 31..27 of the delay register
// RL5 - first-wave bit 16 set switches pulse-width measurement off
// RL6 - first-wave bit 15 selects recognition edge, 0 rising, 1 falling
// RL7 - first-wave bit 14 adds an extra +20 mV comparator offset
// RL8 - first-wave bit 13 adds an extra -20 mV comparator offset
// RL9 - first-wave bits 12..8 give two's-complement trim in 1 mV steps
// RL10 - fire bit 31 enables both outputs with the downstream one inverted
// RL11 - fire bit 30 disables upstream output, bit 29 disables downstream output
// RL12 - fire bit 28 switches on the start-channel noise unit
// RL13 - host enables bit 27 noise unit when start derives from ref clock
// RL14 - fire bits 26..24 repeat the pulse sequence zero to seven times
// RL15 - fire bits 23..8 hold one invert bit per pulse, up to 15 pulses
// RL16 - first-wave enable switches delay register between its two layouts
// RL17 - lowest phase bit controls first pulse, later bits following pulses
module tdcfc_top #(
    parameter int FIRE_HALF = tdcfc_pkg::FIRE_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [tdcfc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [tdcfc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [tdcfc_pkg::DATA_W-1:0] rdata_o,
    // mode and fire control from the rest of the device
    input wire logic first_wave_en_i,
    input wire logic fire_start_i,
    input wire logic [tdcfc_pkg::COUNT_W-1:0] fire_pulse_count_i,
    // stop window
    output logic [tdcfc_pkg::DELAY_W-1:0] third_stop_enable_delay_o,
    output logic [tdcfc_pkg::DELAY_INT_W-1:0] delay_int_o,
    output logic [tdcfc_pkg::DELAY_FRAC_W-1:0] delay_frac_o,
    // first-wave analog settings
    output logic pulse_width_measure_en_o,
    output logic first_echo_edge_select_o,
    output logic signed [tdcfc_pkg::COMPARATOR_TRIM_W-1:0] comparator_offset_mv_o,
    // noise units
    output logic start_noise_on_o,
    output logic noise_unit_ctrl_o,
    // fire outputs
    output logic fire_up_o,
    output logic fire_down_o,
    output logic fire_busy_o
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [tdcfc_pkg::DATA_W-1:0] delay_cfg_r;
    logic [tdcfc_pkg::DATA_W-1:0] fire_cfg_r;
    logic [tdcfc_pkg::DATA_W-1:0] rdata_r;
    logic wr_delay;
    logic wr_fire;

    assign wr_delay = wr_i && (addr_i == tdcfc_pkg::REG_DELAY_IDX);
    assign wr_fire = wr_i && (addr_i == tdcfc_pkg::REG_FIRE_IDX);

    // delay register: all 32 bits stored as written, keep field resets to 2
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            delay_cfg_r <= tdcfc_pkg::DELAY_RESET; // [RL4]
        end else if (wr_delay) begin
            delay_cfg_r <= wdata_i; // [RL3]
        end
    end

    // fire register: plain storage, decoded below
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fire_cfg_r <= tdcfc_pkg::FIRE_RESET;
        end else if (wr_fire) begin
            fire_cfg_r <= wdata_i; // [RL3]
        end
    end

    // read data answers one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= tdcfc_pkg::READ_ZERO;
        end else if (rd_i && addr_i == tdcfc_pkg::REG_DELAY_IDX) begin
            rdata_r <= delay_cfg_r;
        end else if (rd_i && addr_i == tdcfc_pkg::REG_FIRE_IDX) begin
            rdata_r <= fire_cfg_r;
        end else begin
            rdata_r <= tdcfc_pkg::READ_ZERO;
        end
    end

    assign rdata_o = rdata_r;

    // ------------------------------------------------------------------
    // delay register decode, layout chosen by first-wave mode
    // ------------------------------------------------------------------
    logic [tdcfc_pkg::DELAY_W-1:0] delay_field;
    logic [tdcfc_pkg::TRIM_W-1:0] trim_field;
    logic signed [tdcfc_pkg::COMPARATOR_TRIM_W-1:0] trim_mv;
    logic signed [tdcfc_pkg::COMPARATOR_TRIM_W-1:0] pos_mv;
    logic signed [tdcfc_pkg::COMPARATOR_TRIM_W-1:0] neg_mv;
    logic signed [tdcfc_pkg::COMPARATOR_TRIM_W-1:0] comparator_trim_nxt;
    logic [tdcfc_pkg::DELAY_W-1:0] delay_r;
    logic pw_en_r;
    logic edge_r;
    logic signed [tdcfc_pkg::COMPARATOR_TRIM_W-1:0] comparator_trim_r;

    assign delay_field = delay_cfg_r[tdcfc_pkg::DELAY_LSB +: tdcfc_pkg::DELAY_W];
    assign trim_field = delay_cfg_r[tdcfc_pkg::TRIM_LSB +: tdcfc_pkg::TRIM_W];
    // sign extension turns code 16 into -16 mV and code 31 into -1 mV
    assign trim_mv = {{(tdcfc_pkg::COMPARATOR_TRIM_W - tdcfc_pkg::TRIM_W){trim_field[tdcfc_pkg::TRIM_W-1]}},
                      trim_field}; // [RL9]
    assign pos_mv = delay_cfg_r[tdcfc_pkg::POS_COMPARATOR_TRIM_BIT] ? tdcfc_pkg::EXTRA_COMPARATOR_TRIM_MV : '0; // [RL7]
    assign neg_mv = delay_cfg_r[tdcfc_pkg::NEG_COMPARATOR_TRIM_BIT] ? tdcfc_pkg::EXTRA_COMPARATOR_TRIM_MV : '0; // [RL8]
    // worst case -36..+35 mV fits seven signed bits, so no wrap
    assign comparator_trim_nxt = trim_mv + pos_mv - neg_mv;

    // window delay only exists in the plain layout; zero while first-wave runs
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            delay_r <= '0;
        end else if (first_wave_en_i) begin
            delay_r <= '0; // [RL16]
        end else begin
            delay_r <= delay_field; // [RL1]
        end
    end

    // first-wave fields only act in first-wave mode
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pw_en_r <= 1'b0;
            edge_r <= 1'b0;
            comparator_trim_r <= '0;
        end else if (first_wave_en_i) begin
            pw_en_r <= !delay_cfg_r[tdcfc_pkg::PW_OFF_BIT]; // [RL5]
            edge_r <= delay_cfg_r[tdcfc_pkg::EDGE_BIT]; // [RL6]
            comparator_trim_r <= comparator_trim_nxt; // [RL9]
        end else begin
            pw_en_r <= 1'b0; // [RL16]
            edge_r <= 1'b0;
            comparator_trim_r <= '0;
        end
    end

    assign third_stop_enable_delay_o = delay_r;
    // fraction in the low five bits, integer above, in reference periods
    assign delay_frac_o = delay_r[tdcfc_pkg::DELAY_FRAC_W-1:0]; // [RL2]
    assign delay_int_o = delay_r[tdcfc_pkg::DELAY_W-1:tdcfc_pkg::DELAY_FRAC_W]; // [RL2]
    assign pulse_width_measure_en_o = pw_en_r;
    assign first_echo_edge_select_o = edge_r;
    assign comparator_offset_mv_o = comparator_trim_r;

    // ------------------------------------------------------------------
    // fire configuration decode
    // ------------------------------------------------------------------
    logic up_en;
    logic down_en;
    logic down_inv;
    logic noise_r;
    logic noise_ctrl_r;

    // bit 31 overrides both disables, so the only path to invert is "both on"
    assign up_en = fire_cfg_r[tdcfc_pkg::BOTH_ON_BIT] || !fire_cfg_r[tdcfc_pkg::UP_OFF_BIT];
    assign down_en = fire_cfg_r[tdcfc_pkg::BOTH_ON_BIT] || !fire_cfg_r[tdcfc_pkg::DOWN_OFF_BIT];
    assign down_inv = fire_cfg_r[tdcfc_pkg::BOTH_ON_BIT]; // [RL10]

    // noise controls registered so they stay glitch free toward the start path
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            noise_r <= 1'b0;
            noise_ctrl_r <= 1'b0;
        end else begin
            noise_r <= fire_cfg_r[tdcfc_pkg::START_NOISE_BIT]; // [RL12]
            noise_ctrl_r <= fire_cfg_r[tdcfc_pkg::NOISE_CTRL_BIT]; // [RL13]
        end
    end

    assign start_noise_on_o = noise_r;
    assign noise_unit_ctrl_o = noise_ctrl_r;

    // ------------------------------------------------------------------
    // fire pulse generation
    // ------------------------------------------------------------------
    logic fire_tick;
    logic fire_wave;
    logic fire_busy;
    logic fire_kick;
    logic [tdcfc_pkg::COUNT_W-1:0] pulse_count;
    logic fire_up_r;
    logic fire_down_r;

    // counts above the phase mask length are clipped to fifteen pulses
    assign pulse_count = (fire_pulse_count_i > tdcfc_pkg::COUNT_W'(tdcfc_pkg::MAX_PULSES)) ?
                         tdcfc_pkg::COUNT_W'(tdcfc_pkg::MAX_PULSES) : fire_pulse_count_i; // [RL15]
    assign fire_kick = fire_start_i && !fire_busy;

    tdcfc_clk_div #(
        .HALF_CYCLES(FIRE_HALF)
    ) u_div (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(fire_kick),
        .tick_o(fire_tick)
    );

    tdcfc_fire_train u_train (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(fire_kick),
        .tick_i(fire_tick),
        .pulse_count_i(pulse_count),
        .repeat_i(fire_cfg_r[tdcfc_pkg::REPEAT_LSB +: tdcfc_pkg::REPEAT_W]), // [RL14]
        .phase_i(fire_cfg_r[tdcfc_pkg::PHASE_LSB +: tdcfc_pkg::PHASE_W]), // [RL15]
        .busy_o(fire_busy),
        .wave_o(fire_wave)
    );

    // output stage: enables gate the wave, downstream may be inverted
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fire_up_r <= 1'b0;
            fire_down_r <= 1'b0;
        end else begin
            fire_up_r <= up_en && fire_wave; // [RL11]
            fire_down_r <= down_en && (fire_wave ^ down_inv); // [RL10]
        end
    end

    assign fire_up_o = fire_up_r;
    assign fire_down_o = fire_down_r;
    assign fire_busy_o = fire_busy;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    delay_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL1]
        (wr_delay && !first_wave_en_i) ##1 !first_wave_en_i
        |=> (third_stop_enable_delay_o == $past(wdata_i[26:8], 2)))
        else $error("delay window not taken from write");

    delay_mode_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL16]
        first_wave_en_i |=> (third_stop_enable_delay_o == '0))
        else $error("delay visible in first-wave mode");

    delay_split_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL2]
        {delay_int_o, delay_frac_o} == third_stop_enable_delay_o)
        else $error("delay fixed point split wrong");

    keep_reset_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL4]
        $rose(!reset_i) |-> (delay_cfg_r[31:27] == 5'h02))
        else $error("keep field reset not two");

    tag_no_effect_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL3]
        (wr_delay && wdata_i[31:8] == delay_cfg_r[31:8]) ##1 $stable(first_wave_en_i)
        |=> $stable(comparator_offset_mv_o) && $stable(third_stop_enable_delay_o))
        else $error("tag bits changed behaviour");

    pw_off_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL5]
        (first_wave_en_i && delay_cfg_r[tdcfc_pkg::PW_OFF_BIT]) |=> !pulse_width_measure_en_o)
        else $error("pulse width measure not off");

    edge_sel_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL6]
        first_wave_en_i
        |=> (first_echo_edge_select_o == $past(delay_cfg_r[tdcfc_pkg::EDGE_BIT])))
        else $error("first-wave edge select wrong");

    offset_sum_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL9]
        (first_wave_en_i && delay_cfg_r[14:8] == 7'h10)
        |=> (comparator_offset_mv_o == -7'sd16))
        else $error("trim code 16 not -16 mV");

    offset_pos_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL7]
        (first_wave_en_i && delay_cfg_r[14:8] == 7'h5F)
        |=> (comparator_offset_mv_o == 7'sd19))
        else $error("extra positive offset wrong");

    offset_neg_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL8]
        (first_wave_en_i && delay_cfg_r[14:8] == 7'h21)
        |=> (comparator_offset_mv_o == -7'sd19))
        else $error("extra negative offset wrong");

    up_off_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL11]
        (fire_cfg_r[31:30] == 2'h1) |=> !fire_up_o)
        else $error("upstream fire not disabled");

    down_inv_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL10]
        fire_cfg_r[tdcfc_pkg::BOTH_ON_BIT] |=> (fire_down_o == !$past(fire_wave)))
        else $error("downstream fire not inverted");

    noise_on_a: assert property (@(posedge clk_i) disable iff (reset_i) // [RL12]
        ##1 (start_noise_on_o == $past(fire_cfg_r[tdcfc_pkg::START_NOISE_BIT])))
        else $error("noise unit control lags");

    read_unmapped_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_i && addr_i != tdcfc_pkg::REG_DELAY_IDX && addr_i != tdcfc_pkg::REG_FIRE_IDX)
        |=> (rdata_o == '0))
        else $error("unmapped read not zero");

endmodule // tdcfc_top

// *** tdcfc_top_tb.sv ***
// self-checking bench for the stop-window and fire configuration block
// assumes the host model drives the register port
module tdcfc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 2;
    typedef struct {logic fw; logic [31:0] wd; logic [18:0] dly; logic pw, eg; logic [6:0] off;} tdcfc_row_t;
    // delay layout first, then each first-wave field and trim corner, then back,
    // and last a rewrite that only changes the tag byte
    tdcfc_row_t rows [10] = '{'{0, 32'h17FF_FFA5, 19'h7FFFF, 0, 0, 7'h00},
        '{1, 32'h1001_0000, 19'h0, 0, 0, 7'h00}, '{1, 32'h1000_8F3C, 19'h0, 1, 1, 7'h0F},
        '{1, 32'h1000_5000, 19'h0, 1, 0, 7'h04}, '{1, 32'h1000_3F00, 19'h0, 1, 0, 7'h6B},
        '{1, 32'h1000_1000, 19'h0, 1, 0, 7'h70}, '{1, 32'h1000_5F00, 19'h0, 1, 0, 7'h13},
        '{1, 32'h1000_2100, 19'h0, 1, 0, 7'h6D}, '{0, 32'h1000_7F00, 19'h0007F, 0, 0, 7'h00},
        '{0, 32'h1000_7F5A, 19'h0007F, 0, 0, 7'h00}};
    logic clk_i, reset_i, wr_i, rd_i, first_wave_en_i, fire_start_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic [3:0] fire_pulse_count_i;
    logic [18:0] third_stop_enable_delay_o;
    logic [13:0] delay_int_o;
    logic [4:0] delay_frac_o;
    logic signed [6:0] comparator_offset_mv_o;
    logic pulse_width_measure_en_o, first_echo_edge_select_o, start_noise_on_o, noise_unit_ctrl_o;
    logic fire_up_o, fire_down_o, fire_busy_o;
    int err_total = 0;
    int compares = 0;
    tdcfc_host_model i_host (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
        .rd_o(rd_i), .rdata_i(rdata_o));
    tdcfc_top #(.FIRE_HALF(H)) i_dut (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .first_wave_en_i, .fire_start_i, .fire_pulse_count_i,
        .third_stop_enable_delay_o, .delay_int_o, .delay_frac_o, .pulse_width_measure_en_o,
        .first_echo_edge_select_o, .comparator_offset_mv_o, .start_noise_on_o,
        .noise_unit_ctrl_o, .fire_up_o, .fire_down_o, .fire_busy_o);
    // compare and count
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset pulse of 12 cycles, then defaults read back
    task automatic rst_chk();
        @(posedge clk_i) reset_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        i_host.rd(8'h04, d);
        chk("reg4_rst", d, tdcfc_pkg::DELAY_RESET);
        i_host.rd(8'h05, d);
        chk("reg5_rst", d, tdcfc_pkg::FIRE_RESET);
    endtask
    // program the fire register, launch one train, check every output cycle
    task automatic fire(input logic [31:0] c, input logic [3:0] n);
        int len;
        logic w;
        i_host.wr(8'h05, c);
        repeat (2) @(posedge clk_i);
        #1 chk("noise", {start_noise_on_o, noise_unit_ctrl_o}, c[28:27]);
        @(posedge clk_i);
        fire_start_i <= 1'b1;
        fire_pulse_count_i <= n;
        @(posedge clk_i) fire_start_i <= 1'b0;
        #1 chk("busy", fire_busy_o, 1);
        len = (c[26:24] + 1) * n * 2 * H;
        for (int k = 0; k < len; k++) begin
            @(posedge clk_i) #1 w = ((k % (2 * H)) < H) ^ c[8 + (k / (2 * H)) % n];
            chk("up", fire_up_o, w & (c[31] | !c[30]));
            chk("down", fire_down_o, (c[31] | !c[29]) & (w ^ c[31]));
        end
        chk("busy_end", fire_busy_o, 0);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        reset_i = 1'b1;
        first_wave_en_i = 1'b0;
        fire_start_i = 1'b0;
        fire_pulse_count_i = 4'h0;
        rst_chk();
        foreach (rows[i]) begin
            @(posedge clk_i) first_wave_en_i <= rows[i].fw;
            i_host.wr(8'h04, rows[i].wd);
            repeat (2) @(posedge clk_i);
            #1 chk("delay", third_stop_enable_delay_o, rows[i].dly);
            chk("int", delay_int_o, rows[i].dly[18:5]);
            chk("frac", delay_frac_o, rows[i].dly[4:0]);
            chk("pw_en", pulse_width_measure_en_o, rows[i].pw);
            chk("edge", first_echo_edge_select_o, rows[i].eg);
            chk("offset", $unsigned(comparator_offset_mv_o), rows[i].off);
            i_host.rd(8'h04, d);
            chk("reg4", d, rows[i].wd);
        end
        // inverted down output, upstream off with a repeat, 15 pulses with seven repeats
        fire(32'h8000_0200, 4'h2);
        fire(32'h4900_0100, 4'h3);
        fire(32'h3740_01C3, 4'hF);
        fire(32'h0000_0000, 4'h1);
        // unmapped address is ignored and reads as zero, read data stand one cycle
        i_host.wr(8'h06, 32'hFFFF_FFFF);
        i_host.rd(8'h06, d);
        chk("unmapped", d, 32'h0000_0000);
        i_host.rd(8'h05, d);
        chk("reg5", d, 32'h0000_0000);
        @(posedge clk_i) #1 chk("rdata_idle", rdata_o, 32'h0000_0000);
        rst_chk();
        finish_test();
    end
endmodule // tdcfc_top_tb
